// ---- acr_config_ctrl.v ----
// Summary of operation
// R1 - Power-down bit enters power save; select bit picks standby (0) or sleep (1).
// R2 - In either power save mode the digital filter halts.
// R3 - Standby keeps oscillator and bias running for quick resume.
// R4 - Host waits about 20 ms after sleep for oscillator start.
// R5 - After power-up the block is in normal mode, power bits zero.
// R6 - Writing the reset-request bit starts a system reset at any time.
// R7 - Completed reset sets the done flag; a configuration read clears it.
// R8 - System reset zeroes config, offset, setup; gains become unity.
// R9 - Reset-request clears itself at end; port returns to command mode.
// R10 - Host sets only reset-request when starting a reset.
// R11 - Input-short bit shorts every channel input pair.
// R12 - Guard bit makes low latch pin drive common mode, ignoring source.
// R13 - Reference-range bit selects the reference sampling capacitor.
// R14 - Latch-source bit picks setup word (0) or configuration bits (1).
// R15 - Configuration source drives pins from bits 24:23 at command execution.
// R16 - Host writes zero to reserved bits 21:0.
// R17 - A write is command byte plus exactly 32 data bits.
// R18 - Done flag clears only after all 32 read bits are shifted out.
`include "acr_defines.vh"
`timescale 1ns/100ps
`default_nettype none
module acr_config_ctrl (
   input wire ref_clk_i,
   input wire sys_rst_i,
   input wire clk_en_i,
   // Serial command port pins
   input wire port_sel_n_i,
   input wire port_sclk_i,
   input wire port_sdi_i,
   output wire port_sdo_o,
   output wire port_sdo_oe_o,
   // Command execution strobe from the command decoder
   input wire cmd_exec_i,
   // Latch field of the channel setup word in use
   input wire [1:0] setup_latch_i,
   // Control outputs to the analog and filter logic
   output wire filter_run_o,
   output wire osc_enable_o,
   output wire bias_enable_o,
   output wire input_ground_short_o,
   output wire reference_range_select_o,
   output wire guard_drive_enable_o,
   output wire latch_pin_low_o,
   output wire latch_pin_high_o,
   // System reset pulse to offset, gain and setup registers
   output wire sys_reset_pulse_o,
   output wire [31:0] gain_reset_value_o,
   output wire [31:0] offset_reset_value_o,
   output wire [31:0] setup_reset_value_o,
   output wire [31:0] converter_configuration_o
);
   ////////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers
   wire sel_n_s;
   wire sclk_s;
   wire sdi_s;
   // Select idles high, so its synchroniser resets to deselected
   acr_sync2 #(.RST_VAL(1'b1)) u_sync_sel (
      .ref_clk_i(ref_clk_i),
      .sys_rst_i(sys_rst_i),
      .clk_en_i(clk_en_i),
      .async_i(port_sel_n_i),
      .sync_o(sel_n_s)
   );
   acr_sync2 u_sync_sclk (
      .ref_clk_i(ref_clk_i),
      .sys_rst_i(sys_rst_i),
      .clk_en_i(clk_en_i),
      .async_i(port_sclk_i),
      .sync_o(sclk_s)
   );
   acr_sync2 u_sync_sdi (
      .ref_clk_i(ref_clk_i),
      .sys_rst_i(sys_rst_i),
      .clk_en_i(clk_en_i),
      .async_i(port_sdi_i),
      .sync_o(sdi_s)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Serial port state
   localparam ST_CMD = 2'b00;
   localparam ST_WRITE = 2'b01;
   localparam ST_READ = 2'b10;
   localparam CMD_WR_CFG = 8'h03;
   localparam CMD_RD_CFG = 8'h0B;

   reg [1:0] state_q;
   reg [1:0] state_d;
   reg sclk_prev_q;
   reg [5:0] bit_cnt_q;
   reg [5:0] bit_cnt_d;
   reg [31:0] shift_q;
   reg [31:0] shift_d;
   reg [31:0] cfg_q;
   reg [31:0] cfg_d;
   reg [7:0] rst_cnt_q;
   reg [7:0] rst_cnt_d;
   reg rst_busy_q;
   reg rst_busy_d;
   reg [1:0] latch_q;
   reg [1:0] latch_d;
   reg sdo_q;
   reg sdo_d;
   reg filter_run_q;
   reg osc_enable_q;
   reg bias_enable_q;
   reg latch_low_q;
   reg latch_high_q;
   reg rst_pulse_q;

   wire rise = sclk_s & ~sclk_prev_q & ~sel_n_s;
   wire fall = ~sclk_s & sclk_prev_q & ~sel_n_s;
   wire [31:0] shift_in = {shift_q[30:0], sdi_s};
   // R14 - latch source select
   wire [1:0] latch_src = cfg_q[`ACR_BIT_LATCH_SRC] ?
      {cfg_q[`ACR_BIT_LATCH_LOW], cfg_q[`ACR_BIT_LATCH_HIGH]} : setup_latch_i;

   // Edge history of the synchronised serial clock
   always @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         sclk_prev_q <= 1'b0;
      end else if (clk_en_i) begin
         sclk_prev_q <= sclk_s;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Port, register and reset-cycle next state
   always @* begin
      state_d = state_q;
      bit_cnt_d = bit_cnt_q;
      shift_d = shift_q;
      cfg_d = cfg_q;
      rst_cnt_d = rst_cnt_q;
      rst_busy_d = rst_busy_q;
      latch_d = latch_q;
      sdo_d = sdo_q;
      // R15 - latch at execution
      // Commands run by the conversion side refresh the latch pins too
      if (cmd_exec_i) begin
         latch_d = latch_src;
      end
      // Shift engine
      case (state_q)
         ST_CMD: begin
            if (rise) begin
               shift_d = shift_in;
               if (bit_cnt_q == 6'h07) begin
                  bit_cnt_d = 6'h00;
                  // R14 - source per command
                  // R15 - latch at execution
                  latch_d = latch_src;
                  if (shift_in[7:0] == CMD_WR_CFG) begin
                     state_d = ST_WRITE;
                  end else if (shift_in[7:0] == CMD_RD_CFG) begin
                     state_d = ST_READ;
                     shift_d = cfg_q;
                  end
               end else begin
                  bit_cnt_d = bit_cnt_q + 6'h01;
               end
            end
         end
         ST_WRITE: begin
            if (rise) begin
               shift_d = shift_in;
               // R17 - 32 data bits
               if (bit_cnt_q == `ACR_WORD_BITS - 6'h01) begin
                  bit_cnt_d = 6'h00;
                  state_d = ST_CMD;
                  // R6 - reset request
                  if (shift_in[`ACR_BIT_RST_REQ]) begin
                     cfg_d[`ACR_BIT_RST_REQ] = 1'b1;
                     rst_busy_d = 1'b1;
                     rst_cnt_d = `ACR_RST_CYCLES;
                  end else begin
                     cfg_d = (shift_in & `ACR_WR_MASK) | (cfg_q & ~`ACR_WR_MASK);
                  end
               end else begin
                  bit_cnt_d = bit_cnt_q + 6'h01;
               end
            end
         end
         ST_READ: begin
            if (fall) begin
               sdo_d = shift_q[31];
               shift_d = {shift_q[30:0], 1'b0};
            end
            if (rise) begin
               // R18 - clear after last bit
               if (bit_cnt_q == `ACR_WORD_BITS - 6'h01) begin
                  bit_cnt_d = 6'h00;
                  state_d = ST_CMD;
                  // R7 - read clears flag
                  cfg_d[`ACR_BIT_RST_DONE] = 1'b0;
               end else begin
                  bit_cnt_d = bit_cnt_q + 6'h01;
               end
            end
         end
         default: begin
            state_d = ST_CMD;
         end
      endcase
      // Deselect aborts a partial frame
      if (sel_n_s) begin
         state_d = ST_CMD;
         bit_cnt_d = 6'h00;
      end
      // Reset cycle runs regardless of port activity
      if (rst_busy_q) begin
         if (rst_cnt_q == 8'h00) begin
            // R8 - clear configuration
            cfg_d = `ACR_CFG_RESET;
            // R7 - set done flag
            cfg_d[`ACR_BIT_RST_DONE] = 1'b1;
            rst_busy_d = 1'b0;
            latch_d = 2'b00;
            // R9 - back to command mode
            state_d = ST_CMD;
            bit_cnt_d = 6'h00;
         end else begin
            rst_cnt_d = rst_cnt_q - 8'h01;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // State registers
   always @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         // R5 - normal mode at power up
         state_q <= ST_CMD;
         bit_cnt_q <= 6'h00;
         shift_q <= 32'h00000000;
         cfg_q <= `ACR_CFG_RESET;
         rst_cnt_q <= 8'h00;
         rst_busy_q <= 1'b0;
         latch_q <= 2'b00;
         sdo_q <= 1'b0;
      end else if (clk_en_i) begin
         state_q <= state_d;
         bit_cnt_q <= bit_cnt_d;
         shift_q <= shift_d;
         cfg_q <= cfg_d;
         rst_cnt_q <= rst_cnt_d;
         rst_busy_q <= rst_busy_d;
         latch_q <= latch_d;
         sdo_q <= sdo_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Output registers load from next-state values, so they change with cfg_q
   always @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         // R5 - full power at reset
         filter_run_q <= 1'b1;
         osc_enable_q <= 1'b1;
         bias_enable_q <= 1'b1;
         latch_low_q <= 1'b0;
         latch_high_q <= 1'b0;
         rst_pulse_q <= 1'b0;
      end else if (clk_en_i) begin
         // R1 - mode select
         // R2 - filter halts
         filter_run_q <= ~cfg_d[`ACR_BIT_PWR_DOWN];
         // R3 - standby keeps oscillator
         osc_enable_q <= ~(cfg_d[`ACR_BIT_PWR_DOWN] & cfg_d[`ACR_BIT_DEPTH_SEL]);
         bias_enable_q <= ~(cfg_d[`ACR_BIT_PWR_DOWN] & cfg_d[`ACR_BIT_DEPTH_SEL]);
         // R12 - guard overrides low pin
         latch_low_q <= cfg_d[`ACR_BIT_GUARD] ? 1'b0 : latch_d[1];
         latch_high_q <= latch_d[0];
         // R8 - pulse in last busy cycle
         rst_pulse_q <= rst_busy_d & (rst_cnt_d == 8'h00);
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Power control, held in the output registers
   assign filter_run_o = filter_run_q;
   assign osc_enable_o = osc_enable_q;
   assign bias_enable_o = bias_enable_q;

   // Analog steering
   // R11 - input short
   assign input_ground_short_o = cfg_q[`ACR_BIT_IN_SHORT];
   // R13 - reference capacitor
   assign reference_range_select_o = cfg_q[`ACR_BIT_REF_RANGE];
   // R12 - guard buffer enable
   assign guard_drive_enable_o = cfg_q[`ACR_BIT_GUARD];
   assign latch_pin_low_o = latch_low_q;
   assign latch_pin_high_o = latch_high_q;

   // R8 - reset pulse and values
   assign sys_reset_pulse_o = rst_pulse_q;
   assign gain_reset_value_o = `ACR_GAIN_RESET;
   assign offset_reset_value_o = `ACR_OFFSET_RESET;
   assign setup_reset_value_o = `ACR_SETUP_RESET;
   assign converter_configuration_o = cfg_q;

   // Serial output enabled while selected and reading
   assign port_sdo_o = sdo_q;
   assign port_sdo_oe_o = ~sel_n_s & (state_q == ST_READ);
endmodule // acr_config_ctrl
`default_nettype wire

// ---- acr_defines.vh ----
`ifndef ACR_DEFINES_VH
`define ACR_DEFINES_VH
// Configuration word field positions
`define ACR_BIT_DEPTH_SEL 31
`define ACR_BIT_PWR_DOWN 30
`define ACR_BIT_RST_REQ 29
`define ACR_BIT_RST_DONE 28
`define ACR_BIT_IN_SHORT 27
`define ACR_BIT_GUARD 26
`define ACR_BIT_REF_RANGE 25
`define ACR_BIT_LATCH_LOW 24
`define ACR_BIT_LATCH_HIGH 23
`define ACR_BIT_LATCH_SRC 22
// Writable bits 31:22 except the read-only done flag
`define ACR_WR_MASK 32'hEFC00000
`define ACR_CFG_RESET 32'h00000000
`define ACR_GAIN_RESET 32'h01000000
`define ACR_OFFSET_RESET 32'h00000000
`define ACR_SETUP_RESET 32'h00000000
// Length of the internal reset cycle
`define ACR_RST_CYCLES 8'h10
// Oscillator restart time after sleep, in microseconds
`define ACR_OSC_START_US 20000
`define ACR_CLK_MHZ 50
`define ACR_WORD_BITS 6'h20
`endif

// ---- acr_sync2.v ----
`timescale 1ns/100ps
`default_nettype none
// Two-stage synchroniser for one pin input
module acr_sync2 #(
   parameter [0:0] RST_VAL = 1'b0
) (
   input wire ref_clk_i,
   input wire sys_rst_i,
   input wire clk_en_i,
   input wire async_i,
   output wire sync_o
);
   reg meta_q;
   reg sync_q;
   // First stage feeds only the second
   always @(posedge ref_clk_i) begin
      // Reset level matches the idle level of the pin, so no false edge follows
      if (sys_rst_i) begin
         meta_q <= RST_VAL;
         sync_q <= RST_VAL;
      end else if (clk_en_i) begin
         meta_q <= async_i;
         sync_q <= meta_q;
      end
   end
   assign sync_o = sync_q;
endmodule // acr_sync2
`default_nettype wire

// ---- acr_cfg_monitor.sv ----
`timescale 1ns/100ps
`default_nettype none
module acr_cfg_monitor (
   input wire ref_clk_i,
   input wire sys_rst_i,
   input wire port_sel_n_i,
   input wire port_sdo_oe_o,
   input wire filter_run_o,
   input wire osc_enable_o,
   input wire bias_enable_o,
   input wire input_ground_short_o,
   input wire reference_range_select_o,
   input wire guard_drive_enable_o,
   input wire latch_pin_low_o,
   input wire sys_reset_pulse_o,
   input wire [31:0] converter_configuration_o
);
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (sys_rst_i);
   wire [31:0] cfg = converter_configuration_o;
   ////////////////////////////////
   // Word held for two cycles, so level outputs have settled
   sequence s_calm;
      $stable(cfg)[*2];
   endsequence
   // Reset cycle ends with only the done flag set
   sequence s_done;
      ##[1:24] cfg == 32'h10000000;
   endsequence
   chk_filter_halt:
      assert property (s_calm |-> filter_run_o == !cfg[30]) else $error("filter run wrong");
   chk_sleep_power:
      assert property (s_calm |-> {osc_enable_o, bias_enable_o} == {2{!(cfg[31] && cfg[30])}})
      else $error("oscillator or bias wrong");
   chk_field_outputs:
      assert property (s_calm |->
         {input_ground_short_o, guard_drive_enable_o, reference_range_select_o} == cfg[27:25])
      else $error("field outputs wrong");
   chk_guard_low:
      assert property (cfg[26] |-> !latch_pin_low_o) else $error("guard pin wrong");
   chk_reset_clear:
      assert property ($rose(cfg[29]) |-> s_done) else $error("reset cycle not finished");
   chk_pulse_end:
      assert property (sys_reset_pulse_o |=> cfg == 32'h10000000 && !sys_reset_pulse_o)
      else $error("reset pulse wrong");
   chk_flag_source:
      assert property (!cfg[28] && !sys_reset_pulse_o |=> !cfg[28]) else $error("flag set wrongly");
   chk_flag_read:
      assert property ($fell(cfg[28]) |-> !port_sel_n_i) else $error("flag cleared outside read");
   chk_sdo_idle:
      assert property (port_sel_n_i[*3] |-> !port_sdo_oe_o) else $error("sdo driven idle");
endmodule // acr_cfg_monitor
`default_nettype wire

// ---- acr_host_model.sv ----
`timescale 1ns/100ps
`default_nettype none
module acr_host_model (
   input wire ref_clk_i,
   input wire port_sdo_i,
   output logic port_sel_n_o,
   output logic port_sclk_o,
   output logic port_sdi_o,
   output logic rd_valid_o,
   output logic [31:0] rd_data_o
);
   // Idle pins: deselected, serial clock still
   initial begin
      port_sel_n_o = 1'h1;
      port_sclk_o = 1'h0;
      port_sdi_o = 1'h0;
      rd_valid_o = 1'h0;
      rd_data_o = 32'h0;
   end
   task automatic xfer(input logic [39:0] w, input int n, input logic rd);
      logic [31:0] r;
      r = 32'h0;
      repeat (6) @(negedge ref_clk_i);
      port_sel_n_o = 1'h0;
      for (int i = 39; i > 39 - n; i--) begin
         repeat (4) @(negedge ref_clk_i);
         port_sdi_o = w[i];
         repeat (4) @(negedge ref_clk_i);
         r = {r[30:0], port_sdi_i_sample()};
         port_sclk_o = 1'h1;
         repeat (4) @(negedge ref_clk_i);
         port_sclk_o = 1'h0;
      end
      repeat (8) @(negedge ref_clk_i);
      port_sel_n_o = 1'h1;
      port_sdi_o = ~port_sdi_o; // Released line shows no stale bit
      rd_valid_o = rd;
      rd_data_o = r;
      @(negedge ref_clk_i);
      rd_valid_o = 1'h0;
   endtask
   function automatic logic port_sdi_i_sample();
      return port_sdo_i;
   endfunction
endmodule // acr_host_model
`default_nettype wire

// ---- adc_config_register_control_bench.sv ----
`timescale 1ns/100ps
`default_nettype none
module adc_config_register_control_bench;
   logic ref_clk_i = 1'h0;
   logic sys_rst_i = 1'h1;
   logic cmd_exec_i = 1'h0;
   logic clk_en_i = 1'h1;
   logic [1:0] setup_latch_i = 2'h0;
   logic [31:0] seed = 32'h0000666E;
   logic [31:0] m = 32'h0; // Expected configuration
   logic f = 1'h0; // Expected done flag
   logic [39:0] q[$];
   int n_errors = 0, n_compared = 0, cyc = 0, n_pulse = 0;
   wire sel_n, sclk, sdi, sdo, sdo_oe, rd_valid, rst_pulse;
   wire [31:0] rd_data, cfg, gain_v, off_v, set_v;
   wire [7:0] ctrl;
   wire sdo_line = sdo_oe ? sdo : ~sdo; // Released line reads as the inverse
   // external clock, so no oscillator start-up wait after sleep
   always #10 ref_clk_i = ~ref_clk_i;
   acr_config_ctrl dut (.ref_clk_i, .sys_rst_i, .clk_en_i, .port_sel_n_i(sel_n),
      .port_sclk_i(sclk), .port_sdi_i(sdi), .port_sdo_o(sdo), .port_sdo_oe_o(sdo_oe),
      .cmd_exec_i, .setup_latch_i, .filter_run_o(ctrl[7]), .osc_enable_o(ctrl[6]),
      .bias_enable_o(ctrl[5]), .input_ground_short_o(ctrl[4]),
      .reference_range_select_o(ctrl[3]), .guard_drive_enable_o(ctrl[2]),
      .latch_pin_low_o(ctrl[1]), .latch_pin_high_o(ctrl[0]), .sys_reset_pulse_o(rst_pulse),
      .gain_reset_value_o(gain_v), .offset_reset_value_o(off_v), .setup_reset_value_o(set_v),
      .converter_configuration_o(cfg));
   acr_host_model host (.ref_clk_i, .port_sdo_i(sdo_line), .port_sel_n_o(sel_n),
      .port_sclk_o(sclk),
      .port_sdi_o(sdi), .rd_valid_o(rd_valid), .rd_data_o(rd_data));
   ////////////////////////////////
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   // Expected control outputs for a word and setup latch field
   function automatic logic [7:0] exp_ctrl(logic [31:0] c, logic [1:0] s);
      logic lo, hi;
      lo = c[22] ? c[24] : s[1];
      hi = c[22] ? c[23] : s[0];
      return {~c[30], {2{~(c[30] & c[31])}}, c[27], c[25], c[26], lo & ~c[26], hi};
   endfunction
   task automatic check(input logic [39:0] seen, input logic [39:0] want);
      n_compared++;
      if (seen !== want) begin
         n_errors++;
         $display("mismatch t=%0t seen=%h want=%h", $time, seen, want);
      end
   endtask
   task automatic wr(input logic [31:0] d);
      host.xfer({8'h03, d}, 40, 1'h0);
      if (d[29]) begin
         repeat (40) @(negedge ref_clk_i);
         m = 32'h0;
         f = 1'h1;
      end else m = d & 32'hEFC00000;
   endtask
   task automatic rd();
      q.push_back({exp_ctrl(m, setup_latch_i), m | {3'h0, f, 28'h0}});
      f = 1'h0;
      host.xfer({8'h0B, 32'h0}, 40, 1'h1);
      check({8'h0, cfg}, {8'h0, m});
   endtask
   task automatic end_sim();
      if (n_errors == 0 && n_compared > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   // Each read result against the oldest expectation
   always @(posedge ref_clk_i) if (rd_valid) check({ctrl, rd_data}, q.pop_front());
   // Reset pulse count and run limit
   always @(posedge ref_clk_i) begin
      if (!sys_rst_i && rst_pulse) n_pulse++;
      if (++cyc == 60000) begin
         n_errors++;
         end_sim();
      end
   end
   // Main sequence
   initial begin
      repeat (20) @(negedge ref_clk_i);
      sys_rst_i = 1'h0;
      rd();
      for (int i = 0; i < 16; i++) begin
         {setup_latch_i, cmd_exec_i} = 3'(rnd());
         wr({i[1:0], 1'h0, 29'(rnd()) & 29'h1FC00000}); // reserved zero, flag refused
         rd();
      end
      host.xfer({8'h03, 32'hFFFFFFFF}, 20, 1'h0); // aborted frame changes nothing
      rd();
      clk_en_i = 1'h0;
      host.xfer({8'h03, 32'h40000000}, 40, 1'h0); // Frozen block ignores a whole frame
      clk_en_i = 1'h1;
      rd();
      wr(32'h20000000); // only the request bit
      check({8'h0, gain_v}, {8'h0, 32'h01000000});
      check({8'h0, off_v | set_v}, 40'h0);
      rd();
      rd();
      check(40'(n_pulse), 40'h1);
      end_sim();
   end
endmodule // adc_config_register_control_bench
bind acr_config_ctrl acr_cfg_monitor mon (.ref_clk_i, .sys_rst_i, .port_sel_n_i, .port_sdo_oe_o,
   .filter_run_o, .osc_enable_o, .bias_enable_o, .input_ground_short_o,
   .reference_range_select_o, .guard_drive_enable_o, .latch_pin_low_o, .sys_reset_pulse_o,
   .converter_configuration_o);
`default_nettype wire
